// ===== core/cae_pkg.sv
// Package for the acceptance filter and error register block.
// Assumes a 32-bit AXI4-Lite slave with one register per aligned word.
package cae_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_MISC = 8'h0D;
  localparam logic [7:0] IDX_RXERR = 8'h0E;
  localparam logic [7:0] IDX_TXERR = 8'h0F;
  localparam logic [7:0] IDX_CODE_A = 8'h10;
  localparam logic [7:0] IDX_MASK_A = 8'h14;
  localparam logic [7:0] IDX_CODE_B = 8'h18;
  localparam logic [7:0] IDX_MASK_B = 8'h1C;
  localparam logic [7:0] IDX_CTRL = 8'h20;
  localparam logic [7:0] IDX_STAT = 8'h21;
  localparam logic [7:0] IDX_INT_ST = 8'h22;
  localparam logic [7:0] IDX_INT_MSK = 8'h23;
  localparam logic [7:0] IDX_FG_ID = 8'h24;

  localparam int ADDR_W = 8;

  // Control register fields.
  localparam int CTRL_INIT_RQ = 0;
  localparam int CTRL_SLEEP_RQ = 1;
  localparam int CTRL_RECOV_OPT = 2;
  localparam int CTRL_ORG_LSB = 4;
  // Status register fields.
  localparam int STAT_INIT_ACK = 0;
  localparam int STAT_SLEEP_ACK = 1;
  localparam int STAT_BO_HOLD = 2;
  localparam int STAT_FG_IDE = 3;
  localparam int STAT_HIT_LSB = 4;
  // Interrupt status and mask fields, and the misc hold bit.
  localparam int INT_RX_FULL = 0;
  localparam int INT_BUS_OFF = 1;
  localparam int MISC_BO_HOLD = 0;

  localparam logic [7:0] ERR_CNT_RST = 8'h00;
  localparam logic [31:0] FILT_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Filter organization codes.
  localparam logic [1:0] ORG_32 = 2'h0;
  localparam logic [1:0] ORG_16 = 2'h1;
  localparam logic [1:0] ORG_8 = 2'h2;
  localparam logic [1:0] ORG_CLOSED = 2'h3;

  typedef enum logic [3:0] {
    SEL_NONE, SEL_MISC, SEL_RXERR, SEL_TXERR, SEL_CODE_A, SEL_MASK_A,
    SEL_CODE_B, SEL_MASK_B, SEL_CTRL, SEL_STAT, SEL_INT_ST, SEL_INT_MSK,
    SEL_FG_ID
  } cae_sel_type;

endpackage

// ===== core/cae_filt_if.sv
// Carrier between the register block and its acceptance filter.
// Assumes both ends sit on the same clock; the filter is combinational.
interface cae_filt_if;
  logic [31:0] id;
  logic ide;
  logic [63:0] code;
  logic [63:0] mask;
  logic [1:0] org;
  logic hit;
  logic [2:0] idx;
  modport regs (output id, ide, code, mask, org, input hit, idx);
  modport filt (input id, ide, code, mask, org, output hit, idx);
endinterface

// ===== core/cae_filter.sv
// Acceptance filter: compares the background identifier with the banks.
// Assumes code and mask byte n of each filter pair with identifier byte n.
module cae_filter (
  cae_filt_if.filt f
);

  // A mask bit of one makes the bit a don't-care.
  // masked bit compare
  function automatic logic byte_ok(input logic [7:0] id_b, input logic [7:0] code_b,
                                   input logic [7:0] mask_b);
    return &(~(id_b ^ code_b) | mask_b);
  endfunction

  logic [7:0] m8;
  logic [3:0] m16;
  logic [1:0] m32;
  logic [7:0] hits;

  genvar k;
  generate
    for (k = 0; k < 8; k++) begin : g8
      assign m8[k] = byte_ok(f.id[7:0], f.code[8*k+:8], f.mask[8*k+:8]);
    end
    for (k = 0; k < 4; k++) begin : g16
      assign m16[k] = byte_ok(f.id[7:0], f.code[16*k+:8], f.mask[16*k+:8]) &
                      byte_ok(f.id[15:8], f.code[16*k+8+:8], f.mask[16*k+8+:8]);
    end
    for (k = 0; k < 2; k++) begin : g32
      assign m32[k] = byte_ok(f.id[7:0], f.code[32*k+:8], f.mask[32*k+:8]) &
                      byte_ok(f.id[15:8], f.code[32*k+8+:8], f.mask[32*k+8+:8]) &
                      (!f.ide |
                       (byte_ok(f.id[23:16], f.code[32*k+16+:8], f.mask[32*k+16+:8]) &
                        byte_ok(f.id[31:24], f.code[32*k+24+:8], f.mask[32*k+24+:8])));
    end
  endgenerate

  always_comb begin
    case (f.org)
      cae_pkg::ORG_32: hits = {6'h00, m32};
      cae_pkg::ORG_16: hits = {4'h0, m16};
      cae_pkg::ORG_8: hits = m8;
      default: hits = 8'h00;
    endcase
    f.hit = |hits;
    f.idx = 3'h0;
    // The lowest numbered filter wins when several match.
    for (int i = 7; i >= 0; i--) begin
      if (hits[i]) begin
        f.idx = 3'(i);
      end
    end
  end

endmodule

// ===== core/cae_regs.sv
// Register side of a CAN controller: bus-off hold, error counters, filters.
// Assumes an AXI4-Lite master on aclk and a protocol core on the same clock
// that supplies counters, mode acknowledges, bus-off entry and messages.
//
// Decided for this implementation: register access over AXI4-Lite.

module cae_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [cae_pkg::ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [cae_pkg::ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic init_acknowledge,
  input wire logic sleep_acknowledge,
  input wire logic bus_off_entry,
  input wire logic [7:0] rx_error_count_in,
  input wire logic [7:0] tx_error_count_in,
  input wire logic rx_msg_valid,
  input wire logic [31:0] identifier_bytes,
  input wire logic rx_msg_ide,
  output logic init_request,
  output logic sleep_request,
  output logic user_recovery_option,
  output logic recovery_request,
  output logic bus_off_hold_flag,
  output logic rx_foreground_full,
  output logic [2:0] filter_hit_index,
  output logic irq
);

  typedef struct packed {
    logic awv;
    logic [cae_pkg::ADDR_W-1:0] aw_addr;
    logic wv;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic init_rq;
    logic sleep_rq;
    logic recov_opt;
    logic [1:0] org;
    logic bo_hold;
    logic recov_pulse;
    logic [7:0] rx_err;
    logic [7:0] tx_err;
    logic [63:0] code;
    logic [63:0] mask;
    logic [31:0] bg_id;
    logic bg_ide;
    logic bg_pend;
    logic [31:0] fg_id;
    logic fg_ide;
    logic [2:0] hit_idx;
    logic rx_full;
    logic bo_evt;
    logic [1:0] int_mask;
    logic irq;
  } cae_state_type;

  cae_state_type s_r;
  cae_state_type s_nxt;
  cae_filt_if fi ();

  // Shared by the read and write paths so both see the same map.
  function automatic cae_pkg::cae_sel_type decode(input logic [cae_pkg::ADDR_W-1:0] a);
    cae_pkg::cae_sel_type sel;
    sel = cae_pkg::SEL_NONE;
    if (a == {cae_pkg::IDX_MISC[5:0], 2'b00}) begin
      sel = cae_pkg::SEL_MISC;
    end else if (a == {cae_pkg::IDX_RXERR[5:0], 2'b00}) begin
      sel = cae_pkg::SEL_RXERR;
    end else if (a == {cae_pkg::IDX_TXERR[5:0], 2'b00}) begin
      sel = cae_pkg::SEL_TXERR;
    end else if (a == {cae_pkg::IDX_CODE_A[5:0], 2'b00}) begin
      sel = cae_pkg::SEL_CODE_A;
    end else if (a == {cae_pkg::IDX_MASK_A[5:0], 2'b00}) begin
      sel = cae_pkg::SEL_MASK_A;
    end else if (a == {cae_pkg::IDX_CODE_B[5:0], 2'b00}) begin
      sel = cae_pkg::SEL_CODE_B;
    end else if (a == {cae_pkg::IDX_MASK_B[5:0], 2'b00}) begin
      sel = cae_pkg::SEL_MASK_B;
    end else if (a == {cae_pkg::IDX_CTRL[5:0], 2'b00}) begin
      sel = cae_pkg::SEL_CTRL;
    end else if (a == {cae_pkg::IDX_STAT[5:0], 2'b00}) begin
      sel = cae_pkg::SEL_STAT;
    end else if (a == {cae_pkg::IDX_INT_ST[5:0], 2'b00}) begin
      sel = cae_pkg::SEL_INT_ST;
    end else if (a == {cae_pkg::IDX_INT_MSK[5:0], 2'b00}) begin
      sel = cae_pkg::SEL_INT_MSK;
    end else if (a == {cae_pkg::IDX_FG_ID[5:0], 2'b00}) begin
      sel = cae_pkg::SEL_FG_ID;
    end
    return sel;
  endfunction

  // The filter always looks at the background buffer.
  assign fi.id = s_r.bg_id;
  assign fi.ide = s_r.bg_ide;
  assign fi.code = s_r.code;
  assign fi.mask = s_r.mask;
  assign fi.org = s_r.org;

  cae_filter u_filter (
    .f(fi.filt)
  );

  always_comb begin
    logic in_init;
    logic [31:0] rd;
    logic [1:0] rr;
    logic [31:0] cur;
    cae_pkg::cae_sel_type wsel;
    in_init = s_r.init_rq & init_acknowledge;
    rd = 32'h0000_0000;
    rr = cae_pkg::RESP_OKAY;
    cur = 32'h0000_0000;
    wsel = decode(s_r.aw_addr);
    s_nxt = s_r;
    s_nxt.recov_pulse = 1'b0;

    s_nxt.rx_err = rx_error_count_in;
    s_nxt.tx_err = tx_error_count_in;

    if (awvalid && s_r.awready) begin
      s_nxt.awv = 1'b1;
      s_nxt.aw_addr = awaddr;
    end
    if (wvalid && s_r.wready) begin
      s_nxt.wv = 1'b1;
      s_nxt.w_data = wdata;
      s_nxt.w_strb = wstrb;
    end
    if (bready && s_r.bvalid) begin
      s_nxt.bvalid = 1'b0;
    end

    // A write is carried out once both address and data are held.
    if (s_r.awv && s_r.wv && !s_r.bvalid) begin
      s_nxt.awv = 1'b0;
      s_nxt.wv = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = cae_pkg::RESP_OKAY;
      case (wsel)
        cae_pkg::SEL_MISC: begin
          if (s_r.w_strb[0] && s_r.w_data[cae_pkg::MISC_BO_HOLD] && s_r.bo_hold) begin
            s_nxt.bo_hold = 1'b0;
            s_nxt.recov_pulse = 1'b1;
          end
        end
        cae_pkg::SEL_CODE_A, cae_pkg::SEL_MASK_A, cae_pkg::SEL_CODE_B,
        cae_pkg::SEL_MASK_B: begin
          if (in_init) begin
            for (int b = 0; b < 4; b++) begin
              if (s_r.w_strb[b]) begin
                case (wsel)
                  cae_pkg::SEL_CODE_A: s_nxt.code[8*b+:8] = s_r.w_data[8*b+:8];
                  cae_pkg::SEL_MASK_A: s_nxt.mask[8*b+:8] = s_r.w_data[8*b+:8];
                  cae_pkg::SEL_CODE_B: s_nxt.code[32+8*b+:8] = s_r.w_data[8*b+:8];
                  default: s_nxt.mask[32+8*b+:8] = s_r.w_data[8*b+:8];
                endcase
              end
            end
          end
        end
        cae_pkg::SEL_CTRL: begin
          if (s_r.w_strb[0]) begin
            s_nxt.init_rq = s_r.w_data[cae_pkg::CTRL_INIT_RQ];
            s_nxt.sleep_rq = s_r.w_data[cae_pkg::CTRL_SLEEP_RQ];
            s_nxt.recov_opt = s_r.w_data[cae_pkg::CTRL_RECOV_OPT];
            // The organization is part of the filter setup and is locked likewise.
            if (in_init) begin
              s_nxt.org = s_r.w_data[cae_pkg::CTRL_ORG_LSB+:2];
            end
          end
        end
        cae_pkg::SEL_INT_ST: begin
          if (s_r.w_strb[0]) begin
            if (s_r.w_data[cae_pkg::INT_RX_FULL]) begin
              s_nxt.rx_full = 1'b0;
            end
            if (s_r.w_data[cae_pkg::INT_BUS_OFF]) begin
              s_nxt.bo_evt = 1'b0;
            end
          end
        end
        cae_pkg::SEL_INT_MSK: begin
          if (s_r.w_strb[0]) begin
            s_nxt.int_mask = s_r.w_data[1:0];
          end
        end
        cae_pkg::SEL_RXERR, cae_pkg::SEL_TXERR, cae_pkg::SEL_STAT,
        cae_pkg::SEL_FG_ID: begin
          // Read-only words accept the write and keep their value.
        end
        default: s_nxt.bresp = cae_pkg::RESP_SLVERR;
      endcase
    end

    // Read data is captured on acceptance so it stays stable while rvalid waits.
    case (decode(araddr))
      cae_pkg::SEL_MISC: rd[cae_pkg::MISC_BO_HOLD] = s_r.bo_hold;
      cae_pkg::SEL_RXERR: rd[7:0] = s_r.rx_err;
      cae_pkg::SEL_TXERR: rd[7:0] = s_r.tx_err;
      cae_pkg::SEL_CODE_A: rd = s_r.code[31:0];
      cae_pkg::SEL_MASK_A: rd = s_r.mask[31:0];
      cae_pkg::SEL_CODE_B: rd = s_r.code[63:32];
      cae_pkg::SEL_MASK_B: rd = s_r.mask[63:32];
      cae_pkg::SEL_CTRL: begin
        cur[cae_pkg::CTRL_INIT_RQ] = s_r.init_rq;
        cur[cae_pkg::CTRL_SLEEP_RQ] = s_r.sleep_rq;
        cur[cae_pkg::CTRL_RECOV_OPT] = s_r.recov_opt;
        cur[cae_pkg::CTRL_ORG_LSB+:2] = s_r.org;
        rd = cur;
      end
      cae_pkg::SEL_STAT: begin
        cur[cae_pkg::STAT_INIT_ACK] = init_acknowledge;
        cur[cae_pkg::STAT_SLEEP_ACK] = sleep_acknowledge;
        cur[cae_pkg::STAT_BO_HOLD] = s_r.bo_hold;
        cur[cae_pkg::STAT_FG_IDE] = s_r.fg_ide;
        cur[cae_pkg::STAT_HIT_LSB+:3] = s_r.hit_idx;
        rd = cur;
      end
      cae_pkg::SEL_INT_ST: begin
        cur[cae_pkg::INT_RX_FULL] = s_r.rx_full;
        cur[cae_pkg::INT_BUS_OFF] = s_r.bo_evt;
        rd = cur;
      end
      cae_pkg::SEL_INT_MSK: rd[1:0] = s_r.int_mask;
      cae_pkg::SEL_FG_ID: rd = s_r.fg_id;
      default: rr = cae_pkg::RESP_SLVERR;
    endcase
    if (rready && s_r.rvalid) begin
      s_nxt.rvalid = 1'b0;
    end
    if (arvalid && s_r.arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rd;
      s_nxt.rresp = rr;
    end

    // Hardware sets come after software clears so a coincident event wins.
    if (bus_off_entry) begin
      s_nxt.bo_evt = 1'b1;
      if (s_r.recov_opt) begin
        s_nxt.bo_hold = 1'b1;
        s_nxt.recov_pulse = 1'b0;
      end
    end

    // A pending message is judged one cycle after it lands in the background.
    if (s_r.bg_pend) begin
      if (!fi.hit) begin
        s_nxt.bg_pend = 1'b0;
      end else if (!s_nxt.rx_full) begin
        s_nxt.fg_id = s_r.bg_id;
        s_nxt.fg_ide = s_r.bg_ide;
        s_nxt.hit_idx = fi.idx;
        s_nxt.rx_full = 1'b1;
        s_nxt.bg_pend = 1'b0;
      end
    end
    // An accepted message still waiting for the foreground is lost to a newer one.
    if (rx_msg_valid) begin
      s_nxt.bg_id = identifier_bytes;
      s_nxt.bg_ide = rx_msg_ide;
      s_nxt.bg_pend = 1'b1;
    end

    s_nxt.awready = !s_nxt.awv && !s_nxt.bvalid;
    s_nxt.wready = !s_nxt.wv && !s_nxt.bvalid;
    s_nxt.arready = !s_nxt.rvalid;
    s_nxt.irq = |({s_nxt.bo_evt, s_nxt.rx_full} & s_nxt.int_mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.rx_err <= cae_pkg::ERR_CNT_RST;
      s_r.tx_err <= cae_pkg::ERR_CNT_RST;
      s_r.code <= {cae_pkg::FILT_RST, cae_pkg::FILT_RST};
      s_r.mask <= {cae_pkg::FILT_RST, cae_pkg::FILT_RST};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign awready = s_r.awready;
  assign wready = s_r.wready;
  assign bvalid = s_r.bvalid;
  assign bresp = s_r.bresp;
  assign arready = s_r.arready;
  assign rvalid = s_r.rvalid;
  assign rdata = s_r.rdata;
  assign rresp = s_r.rresp;
  assign init_request = s_r.init_rq;
  assign sleep_request = s_r.sleep_rq;
  assign user_recovery_option = s_r.recov_opt;
  assign recovery_request = s_r.recov_pulse;
  assign bus_off_hold_flag = s_r.bo_hold;
  assign rx_foreground_full = s_r.rx_full;
  assign filter_hit_index = s_r.hit_idx;
  assign irq = s_r.irq;

endmodule

// ===== tb/cae_properties.sv
// Port-level checker for the acceptance filter and error register block.
// Assumes it is bound into every cae_regs instance on one clock.
module cae_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic bus_off_entry,
  input wire logic user_recovery_option,
  input wire logic recovery_request,
  input wire logic bus_off_hold_flag,
  input wire logic rx_foreground_full,
  input wire logic [2:0] filter_hit_index
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_wr_lat;
    awvalid && awready && wvalid && wready |-> ##2 bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer not on time");
  property p_rd_lat;
    arvalid && arready |=> rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer not on time");
  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_rdy_up;
    $rose(aresetn) |-> !awready ##1 awready && wready && arready;
  endproperty
  a_rdy_up: assert property (p_rdy_up) else $error("readies wrong after reset");
  property p_hold_set;
    bus_off_entry && user_recovery_option |=> bus_off_hold_flag;
  endproperty
  a_hold_set: assert property (p_hold_set) else $error("hold flag not set");
  property p_hold_src;
    $rose(bus_off_hold_flag) |-> $past(bus_off_entry) && $past(user_recovery_option);
  endproperty
  a_hold_src: assert property (p_hold_src) else $error("hold flag set alone");
  property p_hold_fall;
    $fell(bus_off_hold_flag) |-> recovery_request;
  endproperty
  a_hold_fall: assert property (p_hold_fall) else $error("hold flag lost");
  property p_rec_pulse;
    recovery_request |-> !bus_off_hold_flag ##1 !recovery_request;
  endproperty
  a_rec_pulse: assert property (p_rec_pulse) else $error("recovery pulse wrong");
  property p_hit_upd;
    $changed(filter_hit_index) |-> $rose(rx_foreground_full);
  endproperty
  a_hit_upd: assert property (p_hit_upd) else $error("hit index moved alone");
endmodule

bind cae_regs cae_properties chk (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
  .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata, .bus_off_entry,
  .user_recovery_option, .recovery_request, .bus_off_hold_flag, .rx_foreground_full,
  .filter_hit_index);

// ===== tb/cae_core_model.sv
// Behavioural protocol core facing the register block.
// Assumes the bench calls send and boff right after a rising edge.
module cae_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic init_request,
  input wire logic sleep_request,
  output logic init_acknowledge,
  output logic sleep_acknowledge,
  output logic bus_off_entry,
  output logic [7:0] rx_error_count_in,
  output logic [7:0] tx_error_count_in,
  output logic rx_msg_valid,
  output logic [31:0] identifier_bytes,
  output logic rx_msg_ide
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {bus_off_entry, rx_msg_valid, rx_msg_ide} = 3'h0;
    {rx_error_count_in, tx_error_count_in} = 16'h0000;
    identifier_bytes = 32'h0000_0000;
  end
  // Acknowledges trail the requests by one cycle, as a real mode change would.
  always @(posedge aclk) begin
    init_acknowledge <= aresetn && init_request;
    sleep_acknowledge <= aresetn && sleep_request;
  end
  // The rx counter steps on each sent message and boff sets the tx counter to 8'h80, so that reads can be told apart.
  task automatic send(input logic [31:0] id, input logic ide);
    identifier_bytes <= id;
    rx_msg_ide <= ide;
    rx_msg_valid <= 1'h1;
    rx_error_count_in <= rx_error_count_in + 8'h01;
    @(posedge aclk);
    rx_msg_valid <= 1'h0;
    // Stale identifier must not be mistaken for a live one.
    identifier_bytes <= ~id;
    rx_msg_ide <= ~ide;
  endtask
  task automatic boff;
    bus_off_entry <= 1'h1;
    tx_error_count_in <= 8'h80;
    @(posedge aclk);
    bus_off_entry <= 1'h0;
  endtask
endmodule

// ===== tb/testbench.sv
// Self-checking bench: AXI4-Lite register tasks and message injection.
// Assumes the core model stands in for the protocol core.
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; $display("wrong value %s expected %h seen %h", n, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, nsend = 8'h00;
  logic [31:0] wdata = 32'h0, rd_val;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, rsp;
  logic awready, wready, bvalid, arready, rvalid, init_request, sleep_request;
  logic user_recovery_option, recovery_request, bus_off_hold_flag, rx_foreground_full, irq;
  logic init_acknowledge, sleep_acknowledge, bus_off_entry, rx_msg_valid, rx_msg_ide;
  logic [31:0] rdata, identifier_bytes;
  logic [7:0] rx_error_count_in, tx_error_count_in;
  logic [2:0] filter_hit_index;
  int fails = 0, comparisons = 0, cyc = 0;
  cae_regs dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
    .rresp, .init_acknowledge, .sleep_acknowledge, .bus_off_entry, .rx_error_count_in,
    .tx_error_count_in, .rx_msg_valid, .identifier_bytes, .rx_msg_ide, .init_request,
    .sleep_request, .user_recovery_option, .recovery_request, .bus_off_hold_flag,
    .rx_foreground_full, .filter_hit_index, .irq);
  cae_core_model core (.aclk, .aresetn, .init_request, .sleep_request, .init_acknowledge,
    .sleep_acknowledge, .bus_off_entry, .rx_error_count_in, .tx_error_count_in,
    .rx_msg_valid, .identifier_bytes, .rx_msg_ide);
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
  end
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic ad, dd;
    ad = 1'h0;
    dd = 1'h0;
    @(posedge aclk);
    awvalid <= 1'h1;
    awaddr <= {idx[5:0], 2'h0};
    wvalid <= 1'h1;
    wdata <= d;
    bready <= 1'h1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        ad = 1'h1;
        awvalid <= 1'h0;
      end
      if (wvalid && wready) begin
        dd = 1'h1;
        wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    rsp = bresp;
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] idx);
    @(posedge aclk);
    arvalid <= 1'h1;
    araddr <= {idx[5:0], 2'h0};
    rready <= 1'h1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'h0;
    while (!rvalid) @(posedge aclk);
    rd_val = rdata;
    rsp = rresp;
    rready <= 1'h0;
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [31:0] e, input string n);
    rd(idx);
    `CHK(n, e, rd_val)
  endtask
  // Organization is only taken in init mode, so enter it, set, and leave.
  task automatic set_org(input logic [1:0] o);
    wr(cae_pkg::IDX_CTRL, {26'h0, o, 4'h1});
    wr(cae_pkg::IDX_CTRL, {26'h0, o, 4'h0});
  endtask
  task automatic msg(input logic [31:0] id, input logic ide, input logic acc,
      input logic [2:0] hit);
    @(posedge aclk);
    core.send(id, ide);
    nsend++;
    repeat (3) @(posedge aclk);
    `CHK("rx full", acc, rx_foreground_full)
    `CHK("irq", acc, irq)
    if (acc) begin
      `CHK("hit index", hit, filter_hit_index)
      wr(cae_pkg::IDX_INT_ST, 32'h1);
      `CHK("rx full clear", 1'h0, rx_foreground_full)
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    wr(cae_pkg::IDX_CTRL, 32'h3);
    `CHK("mode requests", 2'h3, {sleep_request, init_request})
    rchk(cae_pkg::IDX_STAT, 32'h3, "mode acks");
    rchk(cae_pkg::IDX_RXERR, 32'h0, "rx count reset");
    rchk(cae_pkg::IDX_TXERR, 32'h0, "tx count reset");
    rchk(cae_pkg::IDX_CODE_A, 32'h0, "code a reset");
    rchk(cae_pkg::IDX_MASK_B, 32'h0, "mask b reset");
    rd(8'h30);
    `CHK("unmapped resp", cae_pkg::RESP_SLVERR, rsp)
    wr(8'h30, 32'h0);
    `CHK("unmapped write resp", cae_pkg::RESP_SLVERR, rsp)
    $display("test reset done");
    wr(cae_pkg::IDX_CTRL, 32'h0);
    `CHK("write resp", cae_pkg::RESP_OKAY, rsp)
    wr(cae_pkg::IDX_TXERR, 32'hFF);
    wr(cae_pkg::IDX_RXERR, 32'hFF);
    wr(cae_pkg::IDX_CODE_A, 32'hFFFF_FFFF);
    wr(cae_pkg::IDX_CTRL, 32'h1);
    rchk(cae_pkg::IDX_TXERR, 32'h0, "tx count written");
    rchk(cae_pkg::IDX_RXERR, 32'h0, "rx count written");
    rchk(cae_pkg::IDX_CODE_A, 32'h0, "code a locked");
    wr(cae_pkg::IDX_CODE_A, 32'h4433_2211);
    wr(cae_pkg::IDX_MASK_A, 32'h0000_0700);
    wr(cae_pkg::IDX_CODE_B, 32'h8877_6655);
    wr(cae_pkg::IDX_MASK_B, 32'h00FF_0700);
    rchk(cae_pkg::IDX_CODE_B, 32'h8877_6655, "code b");
    rchk(cae_pkg::IDX_MASK_B, 32'h00FF_0700, "mask b");
    wr(cae_pkg::IDX_INT_MSK, 32'h1);
    $display("test access done");
    set_org(cae_pkg::ORG_32);
    msg(32'h4433_2211, 1'h1, 1'h1, 3'h0);
    msg(32'h5533_2211, 1'h1, 1'h0, 3'h0);
    msg(32'hFFFF_2511, 1'h0, 1'h1, 3'h0);
    msg(32'h88AA_6655, 1'h1, 1'h1, 3'h1);
    set_org(cae_pkg::ORG_16);
    msg(32'h0000_4433, 1'h1, 1'h1, 3'h1);
    msg(32'h0000_88AB, 1'h1, 1'h1, 3'h3);
    set_org(cae_pkg::ORG_8);
    msg(32'h0000_0066, 1'h1, 1'h1, 3'h5);
    msg(32'h0000_0001, 1'h1, 1'h1, 3'h6);
    set_org(cae_pkg::ORG_CLOSED);
    msg(32'h4433_2211, 1'h1, 1'h0, 3'h0);
    rchk(cae_pkg::IDX_FG_ID, 32'h0000_0001, "foreground id");
    rchk(cae_pkg::IDX_STAT, 32'h68, "foreground status");
    rchk(cae_pkg::IDX_CTRL, 32'h30, "organization");
    $display("test filter done");
    wr(cae_pkg::IDX_CTRL, 32'h4);
    `CHK("recovery option", 1'h1, user_recovery_option)
    core.boff();
    repeat (2) @(posedge aclk);
    `CHK("hold set", 1'h1, bus_off_hold_flag)
    `CHK("irq masked", 1'h0, irq)
    rchk(cae_pkg::IDX_INT_ST, 32'h2, "event status");
    wr(cae_pkg::IDX_INT_MSK, 32'h3);
    `CHK("irq unmasked", 1'h1, irq)
    wr(cae_pkg::IDX_MISC, 32'h0);
    `CHK("hold after zero", 1'h1, bus_off_hold_flag)
    rchk(cae_pkg::IDX_MISC, 32'h1, "misc set");
    wr(cae_pkg::IDX_MISC, 32'h1);
    `CHK("hold cleared", 1'h0, bus_off_hold_flag)
    rchk(cae_pkg::IDX_MISC, 32'h0, "misc clear");
    wr(cae_pkg::IDX_INT_ST, 32'h2);
    `CHK("irq cleared", 1'h0, irq)
    wr(cae_pkg::IDX_CTRL, 32'h0);
    core.boff();
    repeat (2) @(posedge aclk);
    `CHK("hold without option", 1'h0, bus_off_hold_flag)
    `CHK("irq on event", 1'h1, irq)
    $display("test bus off done");
    wr(cae_pkg::IDX_CTRL, 32'h1);
    rchk(cae_pkg::IDX_RXERR, {24'h0, nsend}, "rx count");
    rchk(cae_pkg::IDX_TXERR, 32'h80, "tx count");
    $display("test counters done");
    conclude();
  end
endmodule
